// [flash_guard_pkg.sv]
// Purpose: Shared constants for the self-programming guard.
// Assumes: Word-addressed program flash of 64K words.
// Notes: Register offsets are byte addresses on the AHB-Lite port.
package flash_guard_pkg;
  // ----------------------------------------------------------------
  // Flash map
  // ----------------------------------------------------------------
  localparam logic [15:0] STALL_START = 16'hf000;
  // Loader region start per boot size fuse value, all at or above STALL_START
  localparam logic [3:0][15:0] LOADER_START = {16'hfe00, 16'hfc00, 16'hf800, 16'hf000};
  localparam logic [1:0] BOOT_SIZE_RST = 2'h0;
  localparam logic [15:0] BLOCKED_DATA = 16'hffff;

  // ----------------------------------------------------------------
  // Commands and lock bits
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_ERASE = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_LOCK = 2'h3;
  localparam int LK_LDR_LO = 0;
  localparam int LK_LDR_HI = 1;
  localparam int LK_APP_LO = 2;
  localparam int LK_APP_HI = 3;
  localparam logic [3:0] LOCK_ERASED = 4'hf;
  localparam logic [2:0] STORE_WINDOW_CYC = 3'h4;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam int CTRL_ARM = 0;
  localparam int CTRL_REEN = 1;
  localparam int ST_PROG_BUSY = 0;
  localparam int ST_REGION_BUSY = 1;
  localparam int ST_STALL = 2;
  localparam int ST_LOCK_LSB = 4;
  localparam int ST_BOOT_LSB = 8;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_IGNORED = 1;
  localparam int IRQ_BLOCKED = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } prog_state_e;
endpackage : flash_guard_pkg

// [region_if.sv]
// Purpose: Carries addresses to the region decoder and its verdicts back.
// Assumes: All signals combinational on the hclk domain.
// Notes: Word addresses throughout.
`timescale 1ns/1ps
interface region_if;
  logic [1:0] boot_size;
  logic [15:0] pc_addr;
  logic [15:0] tgt_addr;
  logic [15:0] ld_addr;
  logic pc_in_loader;
  logic tgt_in_loader;
  logic tgt_in_stall;
  logic ld_in_loader;
  logic ld_in_stall;
  modport dec (input boot_size, pc_addr, tgt_addr, ld_addr,
    output pc_in_loader, tgt_in_loader, tgt_in_stall, ld_in_loader, ld_in_stall);
  modport user (output boot_size, pc_addr, tgt_addr, ld_addr,
    input pc_in_loader, tgt_in_loader, tgt_in_stall, ld_in_loader, ld_in_stall);
endinterface : region_if

// [region_decode.sv]
// Purpose: Classifies addresses into loader/application and stalling regions.
// Assumes: Boot size already captured and stable.
// Notes: Pure combinational compare against package boundaries.
`timescale 1ns/1ps
module region_decode (
  region_if.dec rif
);
  // ----------------------------------------------------------------
  // Boundary compares
  // ----------------------------------------------------------------
  wire [15:0] loader_start = flash_guard_pkg::LOADER_START[rif.boot_size];
  // Every loader start sits at or above the stall boundary, so loader implies stall
  assign rif.pc_in_loader = (rif.pc_addr >= loader_start);
  assign rif.tgt_in_loader = (rif.tgt_addr >= loader_start);
  assign rif.tgt_in_stall = (rif.tgt_addr >= flash_guard_pkg::STALL_START);
  assign rif.ld_in_loader = (rif.ld_addr >= loader_start);
  assign rif.ld_in_stall = (rif.ld_addr >= flash_guard_pkg::STALL_START);
endmodule : region_decode

// [flash_self_program_guard.sv]
// Purpose: Guards core self-programming of flash: locks, stall, busy flag.
// Assumes: Core-side and programming-side inputs are on hclk.
// Notes: Zero-wait AHB-Lite slave; ce low freezes everything, bus too.
`timescale 1ns/1ps
module flash_self_program_guard (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic [1:0] boot_size_fuses,
  input wire logic [3:0] lock_init,
  input wire logic ivsel_loader,
  input wire logic [15:0] pc_addr,
  input wire logic store_req,
  input wire logic [1:0] store_cmd,
  input wire logic [15:0] store_addr,
  input wire logic [3:0] store_wdata,
  input wire logic load_req,
  input wire logic [15:0] load_addr,
  input wire logic [15:0] flash_rdata,
  output logic load_valid,
  output logic [15:0] load_rdata,
  output logic prog_start,
  output logic [1:0] prog_kind,
  output logic [15:0] prog_addr,
  input wire logic prog_done,
  output logic core_stall,
  output logic region_busy_flag,
  output logic int_allow,
  input wire logic chip_erase,
  input wire logic ext_lock_wr,
  input wire logic [3:0] ext_lock_data
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  flash_guard_pkg::prog_state_e state_q;
  logic init_q;
  logic [1:0] boot_q;
  logic [3:0] lock_q;
  logic [2:0] win_q;
  logic stall_tgt_q;
  logic rbusy_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [flash_guard_pkg::IRQ_W-1:0] irq_st_q;
  logic [flash_guard_pkg::IRQ_W-1:0] irq_mask_q;

  region_if rif ();
  region_decode u_dec (.rif(rif));
  assign rif.boot_size = boot_q;
  assign rif.pc_addr = pc_addr;
  assign rif.tgt_addr = store_addr;
  assign rif.ld_addr = load_addr;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire bus_req = hsel & htrans[1] & hready & (hsize == flash_guard_pkg::HSIZE_WORD);
  wire wr_ctrl = wr_pend_q & (wr_addr_q == flash_guard_pkg::REG_CTRL);
  wire wr_irq_st = wr_pend_q & (wr_addr_q == flash_guard_pkg::REG_IRQ_STATUS);
  wire wr_mask = wr_pend_q & (wr_addr_q == flash_guard_pkg::REG_IRQ_MASK);
  wire arm = wr_ctrl & hwdata[flash_guard_pkg::CTRL_ARM];
  wire reen = wr_ctrl & hwdata[flash_guard_pkg::CTRL_REEN];
  wire idle = (state_q == flash_guard_pkg::ST_IDLE);
  wire run = (state_q == flash_guard_pkg::ST_RUN);

  // ----------------------------------------------------------------
  // Store classification
  // ----------------------------------------------------------------
  // Stores outside the armed window never reach the flash
  wire win_open = (win_q != 3'h0);
  wire store_go = store_req & win_open & idle;
  wire is_prog = (store_cmd == flash_guard_pkg::CMD_ERASE) |
                 (store_cmd == flash_guard_pkg::CMD_WRITE);
  wire ignored = store_go & ~rif.pc_in_loader;
  // Only the low bits of the loader and application pairs decide; general lock modes are not consulted
  wire wr_blocked = rif.tgt_in_loader ? ~lock_q[flash_guard_pkg::LK_LDR_LO]
                                      : ~lock_q[flash_guard_pkg::LK_APP_LO];
  wire prog_go = store_go & rif.pc_in_loader & is_prog & ~wr_blocked;
  wire blk_store = store_go & rif.pc_in_loader & is_prog & wr_blocked;
  wire lock_go = store_go & rif.pc_in_loader & (store_cmd == flash_guard_pkg::CMD_LOCK);
  wire done_ev = run & prog_done;

  // ----------------------------------------------------------------
  // Load classification
  // ----------------------------------------------------------------
  wire rd_lock_blk = (~rif.pc_in_loader & rif.ld_in_loader &
                      ~lock_q[flash_guard_pkg::LK_LDR_HI]) |
                     (rif.pc_in_loader & ~rif.ld_in_loader &
                      ~lock_q[flash_guard_pkg::LK_APP_HI]);
  // Concurrent region answers a constant while busy rather than garbage
  wire rd_busy_blk = rbusy_q & ~rif.ld_in_stall;
  wire rd_blk = rd_lock_blk | rd_busy_blk;
  wire blk_load = load_req & rd_blk;

  // ----------------------------------------------------------------
  // Interrupt gating and next values
  // ----------------------------------------------------------------
  wire gate_app = ~lock_q[flash_guard_pkg::LK_APP_HI] & ivsel_loader &
                  ~rif.pc_in_loader;
  wire gate_ldr = ~lock_q[flash_guard_pkg::LK_LDR_HI] & ~ivsel_loader &
                  rif.pc_in_loader;
  wire [3:0] sw_and = lock_go ? store_wdata : flash_guard_pkg::LOCK_ERASED;
  wire [3:0] ext_and = ext_lock_wr ? ext_lock_data : flash_guard_pkg::LOCK_ERASED;
  wire [3:0] lock_d = lock_q & sw_and & ext_and;
  wire [flash_guard_pkg::IRQ_W-1:0] ev = {blk_store | blk_load, ignored, done_ev};
  wire [flash_guard_pkg::IRQ_W-1:0] w1c = wr_irq_st ? hwdata[flash_guard_pkg::IRQ_W-1:0]
                                                    : '0;
  // Set wins over a clear in the same cycle
  wire [flash_guard_pkg::IRQ_W-1:0] irq_st_d = (irq_st_q & ~w1c) | ev;
  wire [31:0] status_word = {22'h0, boot_q, lock_q, 1'b0, core_stall, rbusy_q, run};
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_mux =
    (ra == flash_guard_pkg::REG_CTRL) ? {31'h0, win_open} :
    (ra == flash_guard_pkg::REG_STATUS) ? status_word :
    (ra == flash_guard_pkg::REG_IRQ_STATUS) ? {29'h0, irq_st_q} :
    (ra == flash_guard_pkg::REG_IRQ_MASK) ? {29'h0, irq_mask_q} : 32'h0;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Write data arrive one cycle after the address, so the address is parked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= flash_guard_pkg::HRESP_OKAY;
    end else if (ce) begin
      wr_pend_q <= bus_req & hwrite;
      wr_addr_q <= haddr[7:0];
      hrdata <= (bus_req & ~hwrite) ? rd_mux : 32'h0;
    end
  end

  // Straps are caught on the first enabled edge after release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_q <= 1'b0;
      boot_q <= flash_guard_pkg::BOOT_SIZE_RST;
      lock_q <= flash_guard_pkg::LOCK_ERASED;
    end else if (ce) begin
      init_q <= 1'b1;
      if (!init_q) begin
        boot_q <= boot_size_fuses;
      end
      if (chip_erase) begin
        lock_q <= flash_guard_pkg::LOCK_ERASED;
      end else if (!init_q) begin
        lock_q <= lock_init;
      end else begin
        lock_q <= lock_d;
      end
    end
  end

  // Arm window: opened by the control write, closed by use or timeout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_q <= 3'h0;
    end else if (ce) begin
      if (arm) begin
        win_q <= flash_guard_pkg::STORE_WINDOW_CYC;
      end else if (store_go) begin
        win_q <= 3'h0;
      end else if (win_open) begin
        win_q <= win_q - 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Programming sequence
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= flash_guard_pkg::ST_IDLE;
      prog_start <= 1'b0;
      prog_kind <= 2'h0;
      prog_addr <= 16'h0;
      stall_tgt_q <= 1'b0;
    end else if (ce) begin
      prog_start <= prog_go;
      unique case (state_q)
        flash_guard_pkg::ST_IDLE: begin
          if (prog_go) begin
            state_q <= flash_guard_pkg::ST_RUN;
            prog_kind <= store_cmd;
            prog_addr <= store_addr;
            stall_tgt_q <= rif.tgt_in_stall;
          end
        end
        flash_guard_pkg::ST_RUN: begin
          if (prog_done) begin
            state_q <= flash_guard_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= flash_guard_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Halt only for stalling-region targets; the core keeps fetching otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_stall <= 1'b0;
    end else if (ce) begin
      if (prog_go) begin
        core_stall <= rif.tgt_in_stall;
      end else if (done_ev) begin
        core_stall <= 1'b0;
      end
    end
  end

  // Busy flag outlives the operation until software re-enables reading
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rbusy_q <= 1'b0;
    end else if (ce) begin
      if (prog_go) begin
        rbusy_q <= 1'b1;
      end else if (reen & idle) begin
        rbusy_q <= 1'b0;
      end
    end
  end
  assign region_busy_flag = rbusy_q;

  // ----------------------------------------------------------------
  // Load path and interrupt gate
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_valid <= 1'b0;
      load_rdata <= 16'h0;
      int_allow <= 1'b1;
    end else if (ce) begin
      load_valid <= load_req;
      load_rdata <= rd_blk ? flash_guard_pkg::BLOCKED_DATA : flash_rdata;
      int_allow <= ~(gate_app | gate_ldr);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_q <= '0;
      irq_mask_q <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_st_q <= irq_st_d;
      if (wr_mask) begin
        irq_mask_q <= hwdata[flash_guard_pkg::IRQ_W-1:0];
      end
      irq <= |(irq_st_d & (wr_mask ? hwdata[flash_guard_pkg::IRQ_W-1:0] : irq_mask_q));
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_app_store_ignored: assert property (ce && ignored |=>
    !prog_start && irq_st_q[flash_guard_pkg::IRQ_IGNORED])
    else $error("store from application region started programming");
  a_loader_store_start: assert property (ce && prog_go |=>
    prog_start && prog_addr == $past(store_addr) && run)
    else $error("loader store did not start at its address");
  a_boot_boundary: assert property (rif.pc_in_loader ==
    (pc_addr >= flash_guard_pkg::LOADER_START[boot_q]))
    else $error("loader decode ignores boot size");
  a_rww_no_stall: assert property (ce && prog_go && !rif.tgt_in_stall |=> !core_stall)
    else $error("core stalled for concurrent region target");
  a_stalling_region_halt: assert property (ce && prog_go && rif.tgt_in_stall |=>
    (core_stall && run) until (run && prog_done && ce))
    else $error("core not halted through stalling operation");
  a_busy_while_run: assert property (run |-> rbusy_q && region_busy_flag)
    else $error("busy flag low during programming");
  a_loader_in_stall: assert property (rif.pc_in_loader |->
    pc_addr >= flash_guard_pkg::STALL_START)
    else $error("loader region outside stalling region");
  a_lock_one_way: assert property (ce && init_q && !chip_erase |=>
    (lock_q & ~$past(lock_q)) == 4'h0)
    else $error("lock bit returned to one without chip erase");
  a_write_blocked: assert property (ce && blk_store |=>
    !prog_start && irq_st_q[flash_guard_pkg::IRQ_BLOCKED])
    else $error("locked write reached flash");
  a_read_blocked: assert property (ce && load_req && rd_lock_blk |=>
    load_valid && load_rdata == flash_guard_pkg::BLOCKED_DATA)
    else $error("locked read returned flash data");
  a_int_gated: assert property (ce && (gate_app || gate_ldr) |=> !int_allow)
    else $error("interrupt allowed in gated region");
  a_reenable_clear: assert property (ce && reen && idle && !prog_go |=> !rbusy_q)
    else $error("re-enable did not clear busy flag");
  a_window_closed: assert property (ce && store_req && !win_open |=> !prog_start)
    else $error("store outside window took effect");
  a_stall_held: assert property (ce && run && !prog_done |=> stall_tgt_q == $past(stall_tgt_q))
    else $error("stall decision changed mid operation");

  c_stall_prog: cover property (ce && prog_go && rif.tgt_in_stall ##[1:50] done_ev);
  c_rww_prog: cover property (ce && prog_go && !rif.tgt_in_stall ##[1:50] done_ev);
  c_blocked_read: cover property (ce && blk_load);
  c_irq_raised: cover property (irq);
endmodule : flash_self_program_guard

// [core_model.sv]
// Purpose: Core and flash stand-in that issues store and load operations.
// Assumes: Single hclk domain; caller arms the store window first.
// Notes: Flash data is a fixed function of the address; released lines invert.
`timescale 1ns/1ps
module core_model #(
  parameter int PROG_CYC = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic core_stall,
  input wire logic prog_start,
  input wire logic load_valid,
  input wire logic [15:0] load_rdata,
  output logic [15:0] pc_addr = 16'h0,
  output logic store_req = 1'b0,
  output logic [1:0] store_cmd = 2'h0,
  output logic [15:0] store_addr = 16'h0,
  output logic [3:0] store_wdata = 4'h0,
  output logic load_req = 1'b0,
  output logic [15:0] load_addr = 16'h0,
  output logic [15:0] flash_rdata,
  output logic prog_done
);
  // ----------------------------------------------------------------
  // Flash array timing
  // ----------------------------------------------------------------
  int cnt_q;
  assign flash_rdata = load_addr ^ 16'h5a5a;
  // Operation ends a fixed time after start, long enough to watch the stall
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 0;
      prog_done <= 1'b0;
    end else begin
      prog_done <= (cnt_q == 1);
      cnt_q <= prog_start ? PROG_CYC : (cnt_q > 0 ? cnt_q - 1 : 0);
    end
  end

  // Store is issued one cycle after the caller's arm write, inside the window
  task store(input logic [15:0] pc, input logic [1:0] cmd, input logic [15:0] a,
    input logic [3:0] wd);
    @(posedge hclk);
    while (core_stall !== 1'b0) @(posedge hclk);
    pc_addr <= pc;
    store_req <= 1'b1;
    store_cmd <= cmd;
    store_addr <= a;
    store_wdata <= wd;
    @(posedge hclk);
    store_req <= 1'b0;
    store_cmd <= ~cmd;
    store_addr <= ~a;
    store_wdata <= ~wd;
  endtask : store

  // A halted core cannot fetch, so loads wait out the stall
  task load(input logic [15:0] pc, input logic [15:0] a, output logic [15:0] d);
    @(posedge hclk);
    while (core_stall !== 1'b0) @(posedge hclk);
    pc_addr <= pc;
    load_req <= 1'b1;
    load_addr <= a;
    @(posedge hclk);
    load_req <= 1'b0;
    load_addr <= ~a;
    #1;
    d = (load_valid === 1'b1) ? load_rdata : 16'hxxxx;
  endtask : load
endmodule : core_model

// [flash_self_program_guard_tb_top.sv]
// Purpose: Self-checking bench for the self-programming guard.
// Assumes: Zero-wait bus slave; core_model stands in for core and flash.
// Notes: Lock modes are swept by chip erase followed by one external write.
`timescale 1ns/1ps
module flash_self_program_guard_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] boot_size_fuses = 2'h1;
  logic ivsel_loader = 1'b0;
  logic chip_erase = 1'b0;
  logic ext_lock_wr = 1'b0;
  logic [3:0] ext_lock_data = 4'h0;
  logic hreadyout, hresp, irq, store_req, load_req, prog_done, load_valid, prog_start;
  logic core_stall, region_busy_flag, int_allow;
  logic [31:0] hrdata;
  logic [1:0] store_cmd, prog_kind;
  logic [15:0] pc_addr, store_addr, load_addr, flash_rdata, load_rdata, prog_addr;
  logic [3:0] store_wdata;
  logic [15:0] d;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  always #10 hclk = ~hclk;

  flash_self_program_guard DUT (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .boot_size_fuses,
    .lock_init(4'hf), .ivsel_loader, .pc_addr, .store_req, .store_cmd, .store_addr,
    .store_wdata, .load_req, .load_addr, .flash_rdata, .load_valid, .load_rdata, .prog_start,
    .prog_kind, .prog_addr, .prog_done, .core_stall, .region_busy_flag, .int_allow,
    .chip_erase, .ext_lock_wr, .ext_lock_data);

  core_model core (.hclk, .hresetn, .core_stall, .prog_start, .pc_addr, .store_req,
    .store_cmd, .store_addr, .store_wdata, .load_req, .load_addr, .flash_rdata, .prog_done,
    .load_valid, .load_rdata);

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      complete_run();
    end
  end

  task complete_run;
    $display("errors=%0d compares=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Single word transfer; data taken at the edge that ends the data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= flash_guard_pkg::HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask : rdc

  function automatic logic [31:0] stat(input logic [3:0] lk, input logic [1:0] bs);
    return ({30'h0, bs} << flash_guard_pkg::ST_BOOT_LSB) |
      ({28'h0, lk} << flash_guard_pkg::ST_LOCK_LSB);
  endfunction : stat

  // Arm, store, then look at the start pulse once it has landed
  task op(input logic [15:0] pc, input logic [1:0] c, input logic [15:0] a, input logic s);
    wr(flash_guard_pkg::REG_CTRL, 32'h1);
    core.store(pc, c, a, 4'h0);
    #1;
    chk(prog_start, s);
  endtask : op

  // Poll status until no operation runs
  task wait_idle;
    logic [31:0] s;
    s = 32'h1;
    for (int i = 0; i < 40 && s[0] !== 1'b0; i++) bus(1'b0, flash_guard_pkg::REG_STATUS, 32'h0, s);
    chk(s[0], 1'b0);
  endtask : wait_idle

  // Wait out the operation, then re-enable the busy region
  task settle;
    wait_idle();
    wr(flash_guard_pkg::REG_CTRL, 32'h2);
  endtask : settle

  task pc_int(input logic iv, input logic [15:0] pc, input logic exp);
    @(posedge hclk);
    ivsel_loader <= iv;
    core.store(pc, 2'h0, 16'h0, 4'h0);
    @(posedge hclk);
    #1;
    chk(int_allow, exp);
  endtask : pc_int

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_app_ignored;
    op(16'h1000, flash_guard_pkg::CMD_ERASE, 16'h0100, 1'b0);
    chk(region_busy_flag, 1'b0);
    rdc(flash_guard_pkg::REG_IRQ_STATUS, 32'h2);
    chk(irq, 1'b0);
    wr(flash_guard_pkg::REG_IRQ_MASK, 32'h2);
    @(posedge hclk);
    #1;
    chk(irq, 1'b1);
    wr(flash_guard_pkg::REG_IRQ_STATUS, 32'h2);
    @(posedge hclk);
    #1;
    chk(irq, 1'b0);
    // Clock enable low must swallow a load without an answer
    @(posedge hclk);
    ce <= 1'b0;
    core.load(16'hf800, 16'hf900, d);
    chk(load_valid, 1'b0);
    @(posedge hclk);
    ce <= 1'b1;
  endtask : t_app_ignored

  task t_stall;
    op(16'hf800, flash_guard_pkg::CMD_WRITE, 16'hf040, 1'b1);
    chk(prog_kind, flash_guard_pkg::CMD_WRITE);
    chk(core_stall, 1'b1);
    repeat (3) @(posedge hclk);
    #1;
    chk(core_stall, 1'b1);
    chk(prog_addr, 16'hf040);
    core.load(16'hf800, 16'hf900, d);
    chk(d, 16'hf900 ^ 16'h5a5a);
    settle();
  endtask : t_stall

  task t_concurrent;
    op(16'hf800, flash_guard_pkg::CMD_ERASE, 16'h0100, 1'b1);
    chk(core_stall, 1'b0);
    chk(region_busy_flag, 1'b1);
    core.load(16'hf800, 16'hf900, d);
    chk(d, 16'hf900 ^ 16'h5a5a);
    wait_idle();
    chk(region_busy_flag, 1'b1);
    core.load(16'hf800, 16'h0100, d);
    chk(d, flash_guard_pkg::BLOCKED_DATA);
    settle();
    #1;
    chk(region_busy_flag, 1'b0);
    core.load(16'hf800, 16'h0100, d);
    chk(d, 16'h0100 ^ 16'h5a5a);
    rdc(flash_guard_pkg::REG_IRQ_STATUS, 32'h5);
    wr(flash_guard_pkg::REG_IRQ_STATUS, 32'h7);
  endtask : t_concurrent

  task lock_case(input logic [3:0] v);
    @(posedge hclk);
    chip_erase <= 1'b1;
    @(posedge hclk);
    chip_erase <= 1'b0;
    ext_lock_wr <= 1'b1;
    ext_lock_data <= v;
    @(posedge hclk);
    ext_lock_wr <= 1'b0;
    ext_lock_data <= ~v;
    rdc(flash_guard_pkg::REG_STATUS, stat(v, 2'h1));
    op(16'hf800, flash_guard_pkg::CMD_WRITE, 16'h0200, v[flash_guard_pkg::LK_APP_LO]);
    settle();
    op(16'hf800, flash_guard_pkg::CMD_WRITE, 16'hfa00, v[flash_guard_pkg::LK_LDR_LO]);
    settle();
    core.load(16'hf800, 16'h0300, d);
    chk(d, v[flash_guard_pkg::LK_APP_HI] ? 16'h0300 ^ 16'h5a5a : 16'hffff);
    core.load(16'h1000, 16'hfa00, d);
    chk(d, v[flash_guard_pkg::LK_LDR_HI] ? 16'hfa00 ^ 16'h5a5a : 16'hffff);
    pc_int(1'b1, 16'h1000, v[flash_guard_pkg::LK_APP_HI]);
    pc_int(1'b0, 16'hf800, v[flash_guard_pkg::LK_LDR_HI]);
    wr(flash_guard_pkg::REG_IRQ_STATUS, 32'h7);
  endtask : lock_case

  task t_locks;
    wr(flash_guard_pkg::REG_CTRL, 32'h1);
    core.store(16'hf800, flash_guard_pkg::CMD_LOCK, 16'h0, 4'hb);
    settle();
    wr(flash_guard_pkg::REG_CTRL, 32'h1);
    core.store(16'hf800, flash_guard_pkg::CMD_LOCK, 16'h0, 4'hf);
    settle();
    rdc(flash_guard_pkg::REG_STATUS, stat(4'hb, 2'h1));
    lock_case(4'hf);
    lock_case(4'ha);
    lock_case(4'h0);
    lock_case(4'h5);
  endtask : t_locks

  // Second reset with the smallest loader shifts the region boundary
  task t_boot;
    @(posedge hclk);
    hresetn <= 1'b0;
    boot_size_fuses <= 2'h3;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rdc(flash_guard_pkg::REG_STATUS, stat(4'hf, 2'h3));
    op(16'hfc00, flash_guard_pkg::CMD_WRITE, 16'hfc00, 1'b0);
    op(16'hfe00, flash_guard_pkg::CMD_WRITE, 16'hfc00, 1'b1);
    chk(core_stall, 1'b1);
    settle();
  endtask : t_boot

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(hreadyout, 1'b1);
    chk(hresp, flash_guard_pkg::HRESP_OKAY);
    chk(int_allow, 1'b1);
    rdc(flash_guard_pkg::REG_STATUS, stat(4'hf, 2'h1));
    rdc(8'h10, 32'h0);
    t_app_ignored();
    t_stall();
    t_concurrent();
    t_locks();
    t_boot();
    complete_run();
  end
endmodule : flash_self_program_guard_tb_top
